// ### src/dls_pkg.sv
// Shared constants, line-state codes and types of the lane sequencer
package dls_pkg;

   // Sequencer clock period and nominal unit interval, in picoseconds
   localparam int CLK_PS = 10000;
   localparam int UI_PS  = 6000;
   // Forward-direction trail multiplier; reverse traffic is never sent
   localparam int N_FWD  = 1;

   // Printed durations, in nanoseconds
   localparam int T_CLK_TRAIL_NS = 60;
   localparam int T_CLK_PZ_NS    = 300;
   localparam int T_HS_PREP_NS   = 40;
   localparam int T_HS_PREPX_NS  = 85;
   localparam int T_HS_PZ_NS     = 145;
   localparam int T_HS_EXIT_NS   = 100;
   localparam int T_HS_TRAIL_NS  = 60;
   localparam int T_LPX_NS       = 50;
   localparam int T_EOT_NS       = 105;

   // Least times round up, longest times round down, never below one cycle
   // whole cycle counts
   function automatic int ceil_cyc(input int ps);
      int c;
      c = (ps + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int floor_cyc(input int ps);
      int c;
      c = ps / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int imax(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] C_LPX       = CNT_W'(ceil_cyc(T_LPX_NS * 1000));
   localparam logic [CNT_W-1:0] C_CLK_PREP  = C_LPX;
   localparam logic [CNT_W-1:0] C_CLK_ZERO  = CNT_W'(ceil_cyc(T_CLK_PZ_NS * 1000) - int'(C_CLK_PREP));
   localparam logic [CNT_W-1:0] C_CLK_TRAIL = CNT_W'(ceil_cyc(T_CLK_TRAIL_NS * 1000));
   localparam logic [CNT_W-1:0] C_HS_PREP   = CNT_W'(imax(ceil_cyc(T_HS_PREP_NS * 1000 + 4 * UI_PS), int'(C_LPX)));
   localparam logic [CNT_W-1:0] C_HS_PREPX  = CNT_W'(floor_cyc(T_HS_PREPX_NS * 1000 + 6 * UI_PS));
   localparam logic [CNT_W-1:0] C_HS_ZERO   = CNT_W'(ceil_cyc(T_HS_PZ_NS * 1000 + 10 * UI_PS) - int'(C_HS_PREP));
   localparam logic [CNT_W-1:0] C_HS_TRAIL  = CNT_W'(ceil_cyc(imax(N_FWD * 8 * UI_PS,
                                                     T_HS_TRAIL_NS * 1000 + N_FWD * 4 * UI_PS)));
   localparam logic [CNT_W-1:0] C_EOT_MAX   = CNT_W'(floor_cyc(T_EOT_NS * 1000 + N_FWD * 12 * UI_PS));
   localparam logic [CNT_W-1:0] C_HS_EXIT   = CNT_W'(imax(ceil_cyc(T_HS_EXIT_NS * 1000), int'(C_LPX)));

   localparam int LANES  = 4;
   localparam int BYTE_W = 8;
   localparam logic [BYTE_W-1:0] SYNC_BYTE = 8'hB8;

   // Lane mode: how many lanes carry the interleaved word
   localparam logic [1:0] MODE_4 = 2'h0;
   localparam logic [1:0] MODE_2 = 2'h1;
   localparam logic [1:0] MODE_1 = 2'h2;

   typedef struct packed {
      logic hs_en;
      logic toggle;
      logic trail;
      logic lp_p;
      logic lp_n;
   } dls_line_s;

   localparam dls_line_s LINE_LP11  = '{hs_en: 1'b0, toggle: 1'b0, trail: 1'b0, lp_p: 1'b1, lp_n: 1'b1};
   localparam dls_line_s LINE_LP01  = '{hs_en: 1'b0, toggle: 1'b0, trail: 1'b0, lp_p: 1'b0, lp_n: 1'b1};
   localparam dls_line_s LINE_LP00  = '{hs_en: 1'b0, toggle: 1'b0, trail: 1'b0, lp_p: 1'b0, lp_n: 1'b0};
   localparam dls_line_s LINE_HS0   = '{hs_en: 1'b1, toggle: 1'b0, trail: 1'b0, lp_p: 1'b0, lp_n: 1'b0};
   localparam dls_line_s LINE_HSDAT = '{hs_en: 1'b1, toggle: 1'b1, trail: 1'b0, lp_p: 1'b0, lp_n: 1'b0};
   localparam dls_line_s LINE_TRAIL = '{hs_en: 1'b1, toggle: 1'b0, trail: 1'b1, lp_p: 1'b0, lp_n: 1'b0};

   typedef struct packed {
      logic [1:0]  mode;
      logic        last;
      logic [31:0] data;
   } dls_word_s;

   typedef enum logic [2:0] {C_IDLE, C_LP01, C_PREP, C_ZERO, C_RUN, C_TRAIL, C_EXIT} dls_cstate_e;
   typedef enum logic [2:0] {D_IDLE, D_LP01, D_PREP, D_ZERO, D_SEND, D_DRAIN, D_TRAIL, D_EXIT} dls_dstate_e;
   typedef enum logic [1:0] {L_IDLE, L_SYNC, L_WAIT, L_SHIFT} dls_lstate_e;

endpackage

// ### src/dls_lane_sequencer.sv
// Transmit lane sequencer: one clock lane and four data lanes, LP/HS entry and exit timing
`timescale 1ns/1ns
module dls_lane_sequencer (
   input  wire logic                                            ref_clk,
   input  wire logic                                            rst,
   input  wire logic                                            hs_clk,
   input  wire logic                                            hs_mode,
   input  wire logic [1:0]                                      lane_mode,
   input  wire logic                                            tx_valid,
   output logic                                                 tx_ready,
   input  wire logic [31:0]                                     tx_data,
   input  wire logic                                            tx_last,
   output logic                                                 busy,
   output dls_pkg::dls_line_s                                   clk_line,
   output dls_pkg::dls_line_s [dls_pkg::LANES-1:0]              data_line,
   output logic [dls_pkg::LANES-1:0][dls_pkg::BYTE_W-1:0]       lane_byte,
   output logic [dls_pkg::LANES-1:0]                            lane_byte_valid
);

   // Clock lane sequencer, ref_clk domain
   dls_pkg::dls_cstate_e             cstate;
   dls_pkg::dls_cstate_e             next_cstate;
   logic [dls_pkg::CNT_W-1:0]        ccnt;
   logic [dls_pkg::CNT_W-1:0]        next_ccnt;

   // Data lane sequencer, ref_clk domain
   dls_pkg::dls_dstate_e             dstate;
   dls_pkg::dls_dstate_e             next_dstate;
   logic [dls_pkg::CNT_W-1:0]        dcnt;
   logic [dls_pkg::CNT_W-1:0]        next_dcnt;

   // Word handshake, ref_clk side
   dls_pkg::dls_word_s               hold;
   dls_pkg::dls_word_s               next_hold;
   logic                             req_tgl;
   logic                             next_req_tgl;
   logic                             pend;
   logic                             next_pend;
   logic                             ack_s1;
   logic                             ack_s2;
   logic                             ack_s3;
   logic                             ack_evt;

   // Link domain state
   logic                             lrst_s1;
   logic                             lrst;
   logic                             go_s1;
   logic                             go_s2;
   logic                             req_s1;
   logic                             req_s2;
   logic                             ack_tgl;
   logic                             next_ack_tgl;
   dls_pkg::dls_lstate_e             lstate;
   dls_pkg::dls_lstate_e             next_lstate;
   dls_pkg::dls_word_s               lw;
   dls_pkg::dls_word_s               next_lw;
   logic [1:0]                       lb;
   logic [1:0]                       next_lb;
   logic [dls_pkg::LANES-1:0][dls_pkg::BYTE_W-1:0] next_byte;
   logic [dls_pkg::LANES-1:0]        next_valid;

   logic                             hs_go;
   logic                             next_hs_go;
   logic                             cnt_done_c;
   logic                             cnt_done_d;

   // Final beat index of a word for a given lane mode
   function automatic logic [1:0] last_beat(input logic [1:0] mode);
      case (mode)
         dls_pkg::MODE_4: last_beat = 2'h0;
         dls_pkg::MODE_2: last_beat = 2'h1;
         default:         last_beat = 2'h3;
      endcase
   endfunction

   assign cnt_done_c = (ccnt == '0);
   assign cnt_done_d = (dcnt == '0);
   assign ack_evt    = ack_s2 ^ ack_s3;
   assign tx_ready   = (dstate == dls_pkg::D_SEND) && !pend;
   assign busy       = (dstate != dls_pkg::D_IDLE) || (cstate != dls_pkg::C_IDLE);

   // Clock lane next state; counts are loaded as duration minus one
   always_comb
   begin
      next_cstate = cstate;
      next_ccnt   = cnt_done_c ? ccnt : ccnt - 1'b1;
      clk_line    = dls_pkg::LINE_LP11;
      case (cstate)
         dls_pkg::C_IDLE:
         begin
            if (hs_mode || tx_valid)
            begin
               next_cstate = dls_pkg::C_LP01;
               next_ccnt   = dls_pkg::C_LPX - 1'b1;
            end
         end
         dls_pkg::C_LP01:
         begin
            clk_line = dls_pkg::LINE_LP01;
            if (cnt_done_c)
            begin
               next_cstate = dls_pkg::C_PREP;
               next_ccnt   = dls_pkg::C_CLK_PREP - 1'b1;
            end
         end
         dls_pkg::C_PREP:
         begin
            clk_line = dls_pkg::LINE_LP00;
            if (cnt_done_c)
            begin
               next_cstate = dls_pkg::C_ZERO;
               next_ccnt   = dls_pkg::C_CLK_ZERO - 1'b1;
            end
         end
         dls_pkg::C_ZERO:
         begin
            clk_line = dls_pkg::LINE_HS0;
            if (cnt_done_c)
               next_cstate = dls_pkg::C_RUN;
         end
         dls_pkg::C_RUN:
         begin
            clk_line = dls_pkg::LINE_HSDAT;
            if (!hs_mode && !tx_valid && dstate == dls_pkg::D_IDLE)
            begin
               next_cstate = dls_pkg::C_TRAIL;
               next_ccnt   = dls_pkg::C_CLK_TRAIL - 1'b1;
            end
         end
         dls_pkg::C_TRAIL:
         begin
            clk_line = dls_pkg::LINE_HS0;
            if (cnt_done_c)
            begin
               next_cstate = dls_pkg::C_EXIT;
               next_ccnt   = dls_pkg::C_HS_EXIT - 1'b1;
            end
         end
         dls_pkg::C_EXIT:
         begin
            if (cnt_done_c)
               next_cstate = dls_pkg::C_IDLE;
         end
         default:
         begin
            next_cstate = dls_pkg::C_EXIT;
            next_ccnt   = dls_pkg::C_HS_EXIT - 1'b1;
         end
      endcase
   end

   // Data lane next state and word handshake; all four lanes move together
   always_comb
   begin
      dls_pkg::dls_line_s ln;
      ln           = dls_pkg::LINE_LP11;
      next_dstate  = dstate;
      next_dcnt    = cnt_done_d ? dcnt : dcnt - 1'b1;
      next_hold    = hold;
      next_req_tgl = req_tgl;
      next_pend    = ack_evt ? 1'b0 : pend;
      case (dstate)
         dls_pkg::D_IDLE:
         begin
            // A burst waits until the clock lane is toggling
            if (tx_valid && cstate == dls_pkg::C_RUN)
            begin
               next_dstate = dls_pkg::D_LP01;
               next_dcnt   = dls_pkg::C_LPX - 1'b1;
            end
         end
         dls_pkg::D_LP01:
         begin
            ln = dls_pkg::LINE_LP01;
            if (cnt_done_d)
            begin
               next_dstate = dls_pkg::D_PREP;
               next_dcnt   = dls_pkg::C_HS_PREP - 1'b1;
            end
         end
         dls_pkg::D_PREP:
         begin
            ln = dls_pkg::LINE_LP00;
            if (cnt_done_d)
            begin
               next_dstate = dls_pkg::D_ZERO;
               next_dcnt   = dls_pkg::C_HS_ZERO - 1'b1;
            end
         end
         dls_pkg::D_ZERO:
         begin
            ln = dls_pkg::LINE_HS0;
            if (cnt_done_d)
               next_dstate = dls_pkg::D_SEND;
         end
         dls_pkg::D_SEND:
         begin
            ln = dls_pkg::LINE_HSDAT;
            if (tx_valid && tx_ready)
            begin
               // lane mode travels with each word
               next_hold    = '{mode: lane_mode, last: tx_last, data: tx_data};
               next_req_tgl = ~req_tgl;
               next_pend    = 1'b1;
               if (tx_last)
                  next_dstate = dls_pkg::D_DRAIN;
            end
         end
         dls_pkg::D_DRAIN:
         begin
            ln = dls_pkg::LINE_HSDAT;
            // Trail only after the link side has shifted out the last word
            if (!pend)
            begin
               next_dstate = dls_pkg::D_TRAIL;
               next_dcnt   = dls_pkg::C_HS_TRAIL - 1'b1;
            end
         end
         dls_pkg::D_TRAIL:
         begin
            ln = dls_pkg::LINE_TRAIL;
            if (cnt_done_d)
            begin
               next_dstate = dls_pkg::D_EXIT;
               next_dcnt   = dls_pkg::C_HS_EXIT - 1'b1;
            end
         end
         dls_pkg::D_EXIT:
         begin
            if (cnt_done_d)
               next_dstate = dls_pkg::D_IDLE;
         end
         default:
         begin
            next_dstate = dls_pkg::D_EXIT;
            next_dcnt   = dls_pkg::C_HS_EXIT - 1'b1;
         end
      endcase
      data_line = {dls_pkg::LANES{ln}};
      // Registered so the link side never samples a decode glitch
      next_hs_go = (next_dstate == dls_pkg::D_SEND) || (next_dstate == dls_pkg::D_DRAIN);
   end

   // Reset enters the exit state so LP-11 is held before the first sequence
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cstate  <= dls_pkg::C_EXIT;
         ccnt    <= dls_pkg::C_HS_EXIT - 1'b1;
         dstate  <= dls_pkg::D_EXIT;
         dcnt    <= dls_pkg::C_HS_EXIT - 1'b1;
         hold    <= '0;
         req_tgl <= 1'b0;
         pend    <= 1'b0;
         hs_go   <= 1'b0;
         ack_s1  <= 1'b0;
         ack_s2  <= 1'b0;
         ack_s3  <= 1'b0;
      end
      else
      begin
         cstate  <= next_cstate;
         ccnt    <= next_ccnt;
         dstate  <= next_dstate;
         dcnt    <= next_dcnt;
         hold    <= next_hold;
         req_tgl <= next_req_tgl;
         pend    <= next_pend;
         hs_go   <= next_hs_go;
         ack_s1  <= ack_tgl;
         ack_s2  <= ack_s1;
         ack_s3  <= ack_s2;
      end
   end

   // Link-domain reset: asserted at once, released in step with hs_clk
   always_ff @(posedge hs_clk or posedge rst)
   begin
      if (rst)
      begin
         lrst_s1 <= 1'b1;
         lrst    <= 1'b1;
      end
      else
      begin
         lrst_s1 <= 1'b0;
         lrst    <= lrst_s1;
      end
   end

   // Link byte engine: sync byte, then each word over one, two or four lanes
   always_comb
   begin
      next_lstate  = lstate;
      next_lw      = lw;
      next_lb      = lb;
      next_ack_tgl = ack_tgl;
      next_byte    = '0;
      next_valid   = '0;
      case (lstate)
         dls_pkg::L_IDLE:
         begin
            if (go_s2)
               next_lstate = dls_pkg::L_SYNC;
         end
         dls_pkg::L_SYNC:
         begin
            next_byte   = {dls_pkg::LANES{dls_pkg::SYNC_BYTE}};
            next_valid  = '1;
            next_lstate = dls_pkg::L_WAIT;
         end
         dls_pkg::L_WAIT:
         begin
            // The held word is stable while its request is pending; a level compare
            // keeps a request that arrived before the sync byte from being lost
            if (req_s2 != ack_tgl)
            begin
               next_lw     = hold;
               next_lb     = 2'h0;
               next_lstate = dls_pkg::L_SHIFT;
            end
            else if (!go_s2)
               next_lstate = dls_pkg::L_IDLE;
         end
         dls_pkg::L_SHIFT:
         begin
            case (lw.mode)
               dls_pkg::MODE_4:
               begin
                  next_byte  = lw.data;
                  next_valid = 4'hF;
               end
               dls_pkg::MODE_2:
               begin
                  next_byte[1:0] = lw.data[lb[0]*16 +: 16];
                  next_valid     = 4'h3;
               end
               default:
               begin
                  next_byte[0] = lw.data[lb*8 +: 8];
                  next_valid   = 4'h1;
               end
            endcase
            if (lb == last_beat(lw.mode))
            begin
               next_ack_tgl = ~ack_tgl;
               next_lstate  = dls_pkg::L_WAIT;
            end
            else
               next_lb = lb + 2'h1;
         end
         default:
            next_lstate = dls_pkg::L_IDLE;
      endcase
   end

   // link side only drives; nothing is sampled from the receiver
   always_ff @(posedge hs_clk or posedge lrst)
   begin
      if (lrst)
      begin
         go_s1           <= 1'b0;
         go_s2           <= 1'b0;
         req_s1          <= 1'b0;
         req_s2          <= 1'b0;
         ack_tgl         <= 1'b0;
         lstate          <= dls_pkg::L_IDLE;
         lw              <= '0;
         lb              <= 2'h0;
         lane_byte       <= '0;
         lane_byte_valid <= '0;
      end
      else
      begin
         go_s1           <= hs_go;
         go_s2           <= go_s1;
         req_s1          <= req_tgl;
         req_s2          <= req_s1;
         ack_tgl         <= next_ack_tgl;
         lstate          <= next_lstate;
         lw              <= next_lw;
         lb              <= next_lb;
         lane_byte       <= next_byte;
         lane_byte_valid <= next_valid;
      end
   end

endmodule

// ### tb/dls_lane_sequencer_asserts.sv
// Line-state timing checks of the lane sequencer
`timescale 1ns/1ns
module dls_seq_checker (
   input wire logic                                ref_clk,
   input wire logic                                rst,
   input wire logic                                hs_mode,
   input wire logic                                tx_ready,
   input wire dls_pkg::dls_line_s                  clk_line,
   input wire dls_pkg::dls_line_s [dls_pkg::LANES-1:0] data_line
);
   localparam dls_pkg::dls_line_s L11 = dls_pkg::LINE_LP11;
   localparam dls_pkg::dls_line_s L01 = dls_pkg::LINE_LP01;
   localparam dls_pkg::dls_line_s L00 = dls_pkg::LINE_LP00;
   localparam dls_pkg::dls_line_s H0  = dls_pkg::LINE_HS0;
   localparam int EOT_MAX = dls_pkg::C_EOT_MAX;
   localparam int CLK_PZ  = dls_pkg::C_CLK_PREP + dls_pkg::C_CLK_ZERO;
   localparam int HS_PZ   = dls_pkg::C_HS_PREP + dls_pkg::C_HS_ZERO;
   dls_pkg::dls_line_s d;
   logic [7:0]         cpz;
   logic [7:0]         dpz;
   logic [7:0]         next_cpz;
   logic [7:0]         next_dpz;
   assign d = data_line[0];
   // Run length of LP-00 plus HS-0, read when the lane starts toggling
   always_comb
   begin
      next_cpz = (clk_line == L00 || clk_line == H0) ? cpz + 8'h01 : 8'h00;
      next_dpz = (d == L00 || d == H0) ? dpz + 8'h01 : 8'h00;
   end
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cpz <= 8'h00;
         dpz <= 8'h00;
      end
      else
      begin
         cpz <= next_cpz;
         dpz <= next_dpz;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   lpx_data_a: assert property (d == L01 && $past(d) != L01 |-> (d == L01) [*5])
      else $error("data lane LP-01 too short");
   clk_trail_a: assert property ($fell(clk_line.toggle) |-> (clk_line == H0) [*6])
      else $error("clock trail too short");
   clk_pz_a: assert property ($rose(clk_line.toggle) |-> cpz >= CLK_PZ)
      else $error("clock prepare plus zero too short");
   hs_prep_a: assert property ($rose(d.hs_en) |-> d == H0 && $past(d) == L00 &&
      dpz >= dls_pkg::C_HS_PREP && dpz <= dls_pkg::C_HS_PREPX) else $error("data prepare out of range");
   hs_pz_a: assert property ($rose(d.toggle) |-> dpz >= HS_PZ)
      else $error("data prepare plus zero too short");
   hs_trail_a: assert property ($rose(d.trail) |-> d.trail [*8] ##1 d.trail)
      else $error("data trail too short");
   eot_max_a: assert property ($rose(d.trail) |-> ##[1:EOT_MAX] d == L11)
      else $error("trail to LP-11 too long");
   hs_exit_a: assert property ($fell(d.hs_en) |-> (d == L11) [*8] ##1 (d == L11) [*2])
      else $error("LP-11 exit too short");
   clk_hold_a: assert property (hs_mode && clk_line.toggle |=> clk_line.toggle)
      else $error("clock stopped in HS mode");
   lanes_same_a: assert property (data_line == {4{d}})
      else $error("data lanes differ");
   ready_hs_a: assert property (tx_ready |-> d == dls_pkg::LINE_HSDAT && clk_line.toggle)
      else $error("payload offered outside HS data");
   cover property ($rose(d.trail));
   cover property ($rose(clk_line.toggle));
   cover property (hs_mode && $fell(d.hs_en) ##1 clk_line.toggle);
endmodule

// ### tb/dls_rx_model.sv
// Receiver model: finds the sync byte, collects payload bytes, switches termination
`timescale 1ns/1ns
module dls_rx_model (
   input wire logic                                           ref_clk,
   input wire logic                                           hs_clk,
   input wire logic                                           rst,
   input wire dls_pkg::dls_line_s [dls_pkg::LANES-1:0]        data_line,
   input wire logic [dls_pkg::LANES-1:0][dls_pkg::BYTE_W-1:0] lane_byte,
   input wire logic [dls_pkg::LANES-1:0]                      lane_byte_valid,
   output logic                                               term_en,
   output int                                                 n_sync
);
   logic [7:0] q[$];
   logic       armed;
   logic       in_burst;
   always @(posedge ref_clk or posedge rst)
      if (rst)
         term_en <= 1'h0;
      else
         term_en <= data_line[0].hs_en || data_line[0] == dls_pkg::LINE_LP00;
   always @(posedge hs_clk or posedge rst)
   begin
      if (rst)
      begin
         armed <= 1'h0;
         in_burst <= 1'h0;
         n_sync <= 0;
      end
      else
      begin
         if (data_line[0] == dls_pkg::LINE_LP11)
            armed <= 1'h1;
         if (armed && lane_byte_valid == 4'hF && lane_byte == {4{dls_pkg::SYNC_BYTE}})
         begin
            armed <= 1'h0;
            in_burst <= 1'h1;
            n_sync <= n_sync + 1;
         end
         else if (in_burst)
            for (int i = 0; i < dls_pkg::LANES; i++)
               if (lane_byte_valid[i])
                  q.push_back(lane_byte[i]);
         if (data_line[0].trail || !data_line[0].hs_en)
            in_burst <= 1'h0;
      end
   end
endmodule

// ### tb/dls_lane_sequencer_bench.sv
// Bench for the lane sequencer: bursts in every lane mode and a held clock lane
`timescale 1ns/1ns
module dls_lane_sequencer_bench;
   logic ref_clk = 1'h0, hs_clk = 1'h0, rst = 1'h1, hs_mode = 1'h0, tx_valid = 1'h0, tx_last = 1'h0;
   logic [1:0]  lane_mode = 2'h0;
   logic [31:0] tx_data = 32'h0;
   logic        tx_ready, busy, term_en;
   logic [3:0]  lane_byte_valid;
   logic [3:0][7:0] lane_byte;
   dls_pkg::dls_line_s clk_line;
   dls_pkg::dls_line_s [3:0] data_line;
   logic [7:0]  expq[$];
   int          n_sync, miscompares = 0, n_compared = 0, cycles = 0;

   dls_lane_sequencer uut (.ref_clk(ref_clk), .rst(rst), .hs_clk(hs_clk), .hs_mode(hs_mode),
      .lane_mode(lane_mode), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .tx_last(tx_last), .busy(busy), .clk_line(clk_line), .data_line(data_line),
      .lane_byte(lane_byte), .lane_byte_valid(lane_byte_valid));
   dls_rx_model rx (.ref_clk(ref_clk), .hs_clk(hs_clk), .rst(rst), .data_line(data_line),
      .lane_byte(lane_byte), .lane_byte_valid(lane_byte_valid), .term_en(term_en), .n_sync(n_sync));

   initial forever #5 ref_clk = ~ref_clk;
   initial
   begin
      #7;
      forever #24 hs_clk = ~hs_clk;
   end

   task automatic results();
      if (miscompares == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One word, held until taken; its bytes are queued lowest first
   task automatic send(input logic [1:0] m, input logic [31:0] w, input logic l);
      int k;
      @(posedge ref_clk);
      tx_valid <= 1'h1;
      lane_mode <= m;
      tx_data <= w;
      tx_last <= l;
      k = 0;
      do @(posedge ref_clk); while (tx_ready !== 1'h1 && ++k < 500);
      chk("word taken", tx_ready, 1'h1);
      tx_valid <= 1'h0;
      for (int i = 0; i < 4; i++)
         expq.push_back(w[8*i+:8]);
   endtask

   task automatic end_burst(input int nsync);
      int k;
      k = 0;
      while (data_line[0] !== dls_pkg::LINE_LP11 && k++ < 2000)
         @(posedge ref_clk);
      repeat (12) @(posedge ref_clk);
      chk("lane idle", data_line[0], dls_pkg::LINE_LP11);
      chk("sync count", n_sync, nsync);
      chk("byte count", rx.q.size(), expq.size());
      while (expq.size() > 0 && rx.q.size() > 0)
         chk("lane byte", rx.q.pop_front(), expq.pop_front());
      expq.delete();
   endtask

   task automatic s_reset();
      repeat (2) @(posedge ref_clk);
      chk("clock lane", clk_line, dls_pkg::LINE_LP11);
      chk("data lane", data_line, {4{dls_pkg::LINE_LP11}});
      chk("ready", tx_ready, 1'h0);
      chk("busy", busy, 1'h1);
   endtask

   task automatic s_single();
      send(dls_pkg::MODE_4, 32'h44332211, 1'h1);
      chk("termination on", term_en, 1'h1);
      end_burst(1);
      chk("termination off", term_en, 1'h0);
   endtask

   task automatic s_modes();
      send(dls_pkg::MODE_2, 32'hA5C3E10F, 1'h0);
      send(dls_pkg::MODE_1, 32'h0123ABCD, 1'h0);
      send(2'h3, 32'hFEDC7654, 1'h0);
      send(dls_pkg::MODE_4, 32'hB8B8B8B8, 1'h1);
      end_burst(2);
   endtask

   task automatic s_hold();
      int k;
      hs_mode <= 1'h1;
      send(dls_pkg::MODE_4, 32'h5A6B7C8D, 1'h1);
      end_burst(3);
      chk("clock held", clk_line, dls_pkg::LINE_HSDAT);
      send(dls_pkg::MODE_1, 32'h00FF0F0F, 1'h1);
      end_burst(4);
      chk("clock held", clk_line, dls_pkg::LINE_HSDAT);
      hs_mode <= 1'h0;
      k = 0;
      do @(posedge ref_clk); while (busy !== 1'h0 && ++k < 500);
      chk("idle", busy, 1'h0);
      chk("clock idle", clk_line, dls_pkg::LINE_LP11);
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         results();
      end
   end

   initial
   begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'h0;
      s_reset();
      s_single();
      s_modes();
      s_hold();
      results();
   end
endmodule

bind dls_lane_sequencer dls_seq_checker chk_i (.ref_clk(ref_clk), .rst(rst), .hs_mode(hs_mode),
   .tx_ready(tx_ready), .clk_line(clk_line), .data_line(data_line));
